// ---- test_watchdog_timer.sv ----
module test_watchdog_timer;
    timeunit 1ns;
    timeprecision 1ps;
    import wd_pkg::*;
    localparam int         POR = 16;
    localparam int         RC  = 32;
    localparam logic [7:0] VEC = 8'h5a;
    logic        clk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [17:0] adr = 18'h0_0000;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic [3:0]  sel = 4'h0;
    logic [7:0]  vec;
    logic        ack, err, oe, pin_o, pin_n, wdr, ilr, irst, vfetch;
    logic        stop_exec = 1'b0, stop_mode = 1'b0, wait_mode = 1'b0, mon_e = 1'b0;
    logic        mon_b = 1'b0, brk = 1'b0, irq_tv = 1'b0, rst_tv = 1'b0, req = 1'b0;
    integer      seed;
    int          miscompares = 0;
    int          tests_run = 0;

    // Open-drain reset pin with a pull-up
    assign pin_n = oe ? pin_o : 1'b1;
    initial forever #4 clk = ~clk;

    wd_top #(.RST_CYC(RC), .POR_CYC(POR)) uut (
        .clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wb_err_o(err), .reset_vector_low(vec), .stop_exec(stop_exec),
        .stop_mode(stop_mode), .wait_mode(wait_mode), .vector_fetch(vfetch),
        .internal_reset(irst), .monitor_entry(mon_e), .monitor_blank(mon_b),
        .break_active(brk), .irq_test_voltage_level(irq_tv),
        .rst_test_voltage_level(rst_tv), .rst_pin_n_i(pin_n), .rst_pin_n_o(pin_o),
        .rst_pin_n_oe(oe), .watchdog_reset(wdr), .illegal_stop_reset(ilr)
    );
    wd_sys_model #(.VEC(VEC)) sys (
        .clk(clk), .reset(reset), .watchdog_reset(wdr), .illegal_stop_reset(ilr),
        .req(req), .reset_vector_low(vec), .internal_reset(irst), .vector_fetch(vfetch)
    );

    function automatic int tmo();
        return (1 << SHORT_EXP) - (1 << KEEP_BITS);
    endfunction

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask

    // One classic cycle; the request stands until ack or err is sampled
    task automatic bus(logic w, logic [17:0] a, logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            complete_run();
        end else begin
            q = rdat;
            e = err;
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
        end
    endtask

    task automatic wr(logic [17:0] a, logic [31:0] d);
        logic [31:0] q;
        logic        e;
        bus(1'b1, a, d, q, e);
    endtask

    task automatic rd(logic [17:0] a, output logic [31:0] q);
        logic e;
        bus(1'b0, a, 32'h0000_0000, q, e);
    endtask

    // Fresh start, one config write, service straight away
    task automatic setup(logic [31:0] cfg);
        logic [31:0] q;
        reset <= 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        repeat (POR + 4) @(posedge clk);
        rd(CFG_ADDR, q);
        chk("config reset", 0, q[2:0]);
        wr(CFG_ADDR, cfg);
        rd(CFG_ADDR, q);
        chk("config", cfg[2:0], q[2:0]);
        wr(SERVICE_ADDR, $random(seed));
    endtask

    // Short timeout plus margin; hit asks for a reset inside the window
    task automatic expect_rst(logic hit);
        int w;
        w = 0;
        for (int i = 1; i <= tmo() + 40 && w == 0; i++) begin
            @(posedge clk);
            if (wdr === 1'b1) w = i;
        end
        // Low four prescaler bits survive the service, so the overflow spreads over 16 cycles
        if (hit) chk("timeout window", 1, {31'h0, w >= tmo() + 1 && w <= tmo() + 16});
        else chk("unexpected reset", 0, w);
    endtask

    task automatic pulse_entry();
        mon_e <= 1'b1;
        @(posedge clk);
        mon_e <= 1'b0;
    endtask

    initial begin
        logic [31:0] q;
        logic        e;
        int          w;
        seed = 32'h31ca_1cde;
        // Short rate in wait mode, random service data and spacing
        setup(32'h0000_0002);
        wait_mode <= 1'b1;
        rd(SERVICE_ADDR, q);
        chk("service read", VEC, q[7:0]);
        bus(1'b0, 18'h0_0100, 32'h0000_0000, q, e);
        chk("unmapped err", 1, e);
        repeat ($random(seed) & 63) @(posedge clk);
        wr(SERVICE_ADDR, $random(seed));
        expect_rst(1'b1);
        w = 0;
        while (oe === 1'b1 && w < 99) begin
            @(posedge clk);
            w++;
        end
        chk("pin low cycles", RC, w);
        rd(STATUS_ADDR, q);
        chk("watchdog cause", 1, q[ST_WD_BIT]);
        rd(STATUS_ADDR, q);
        chk("cause cleared", 0, q[ST_WD_BIT]);
        wait_mode <= 1'b0;
        setup(32'h0000_0000);
        expect_rst(1'b0);
        setup(32'h0000_0003);
        expect_rst(1'b0);
        rd(STATUS_ADDR, q);
        chk("disabled flag", 1, q[ST_DIS_BIT]);
        // Stop allowed: no illegal reset, counting frozen
        setup(32'h0000_0006);
        stop_exec <= 1'b1;
        @(posedge clk);
        stop_exec <= 1'b0;
        stop_mode <= 1'b1;
        expect_rst(1'b0);
        stop_mode <= 1'b0;
        rd(STATUS_ADDR, q);
        chk("no illegal cause", 0, q[ST_ILL_BIT]);
        setup(32'h0000_0002);
        stop_exec <= 1'b1;
        @(posedge clk);
        stop_exec <= 1'b0;
        w = 0;
        repeat (4) begin
            @(posedge clk);
            if (ilr === 1'b1) w = 1;
        end
        chk("illegal stop reset", 1, w);
        rd(STATUS_ADDR, q);
        chk("illegal cause", 1, q[ST_ILL_BIT]);
        setup(32'h0000_0002);
        mon_b <= 1'b1;
        pulse_entry();
        mon_b <= 1'b0;
        expect_rst(1'b0);
        rd(STATUS_ADDR, q);
        chk("blank monitor", 1, q[ST_BLANK_BIT]);
        // Test voltage hands over from one pin to the other, then goes away
        setup(32'h0000_0002);
        irq_tv <= 1'b1;
        // The level needs two synchroniser stages before the entry pulse sees it
        repeat (4) @(posedge clk);
        pulse_entry();
        expect_rst(1'b0);
        rd(STATUS_ADDR, q);
        chk("test voltage hold", 1, q[ST_HOLD_BIT]);
        rst_tv <= 1'b1;
        irq_tv <= 1'b0;
        expect_rst(1'b0);
        rst_tv <= 1'b0;
        repeat (4) @(posedge clk);
        wr(SERVICE_ADDR, $random(seed));
        expect_rst(1'b1);
        setup(32'h0000_0002);
        brk <= 1'b1;
        rst_tv <= 1'b1;
        expect_rst(1'b0);
        brk <= 1'b0;
        rst_tv <= 1'b0;
        // Internal resets alone keep the count away from overflow
        setup(32'h0000_0002);
        for (int k = 0; k < 3; k++) begin
            w = 0;
            repeat (4000) begin
                @(posedge clk);
                if (wdr === 1'b1) w = 1;
            end
            chk("reset despite internal clear", 0, w);
            req <= 1'b1;
            @(posedge clk);
            req <= 1'b0;
        end
        complete_run();
    end
endmodule // test_watchdog_timer

// ---- wd_counter.sv ----
module wd_counter
    import wd_pkg::*;
#(
    parameter int PW = PRE_W,
    parameter int CW = CNT_W
) (
    input  wire logic           clk,
    input  wire logic           reset,
    input  wire logic           run,
    input  wire logic           clr_all,
    input  wire logic           clr_pre,
    input  wire logic           clr_service,
    input  wire logic           rate_short,
    output logic [PW+CW-1:0]    chain_ff,
    output logic                overflow
);
    import wd_pkg::*;

    logic [PW+CW-1:0] nxt_chain;
    logic             long_hit;
    logic             short_hit;

    // Overflow: carry out of the chain, or carry into the short-rate stage
    assign long_hit  = &chain_ff;
    assign short_hit = &chain_ff[SHORT_EXP-1:0];
    assign overflow  = run && !clr_all && !clr_service && (rate_short ? short_hit : long_hit);

    // Next chain value; clears take priority over counting
    always_comb begin
        nxt_chain = chain_ff;
        if (clr_all) begin
            nxt_chain = '0;
        end else begin
            if (run) begin
                nxt_chain = chain_ff + 1'b1;
            end
            if (clr_service) begin
                // Low prescaler stages survive a service clear
                nxt_chain = {{(PW+CW-KEEP_BITS){1'b0}}, nxt_chain[KEEP_BITS-1:0]};
            end
            if (clr_pre) begin
                nxt_chain[PW-1:0] = '0;
            end
        end
    end

    // Prescaler and counter as one free-running chain
    always_ff @(posedge clk) begin
        if (reset) begin
            chain_ff <= '0;
        end else begin
            chain_ff <= nxt_chain;
        end
    end
endmodule // wd_counter

// ---- wd_pkg.sv ----
package wd_pkg;
    // Bus geometry
    localparam int                WB_ADR_W      = 18;
    localparam int                WB_DAT_W      = 32;
    // Register indices and byte addresses
    localparam logic [15:0]       SERVICE_IDX   = 16'hffff;
    localparam logic [17:0]       SERVICE_ADDR  = {SERVICE_IDX, 2'b00};
    localparam logic [17:0]       CFG_ADDR      = 18'h0_0000;
    localparam logic [17:0]       STATUS_ADDR   = 18'h0_0004;
    // Configuration register fields
    localparam int                CFG_DIS_BIT   = 0;
    localparam int                CFG_RATE_BIT  = 1;
    localparam int                CFG_STOPEN_BIT = 2;
    localparam int                CFG_LOCK_BIT  = 3;
    localparam logic [2:0]        CFG_RESET     = 3'h0;
    // Status register fields
    localparam int                ST_WD_BIT     = 0;
    localparam int                ST_ILL_BIT    = 1;
    localparam int                ST_DIS_BIT    = 2;
    localparam int                ST_BLANK_BIT  = 3;
    localparam int                ST_HOLD_BIT   = 4;
    localparam int                ST_CNT_LSB    = 8;
    // Counter structure
    localparam int                PRE_W         = 12;
    localparam int                CNT_W         = 6;
    localparam int                LONG_EXP      = 18;
    localparam int                SHORT_EXP     = 13;
    localparam int                KEEP_BITS     = 4;
    // Timing, counted in oscillator cycles (the block clock is the oscillator clock)
    localparam int                CLK_MHZ       = 125;
    localparam int                RST_PULSE_CYC = 32;
    localparam int                POR_CLR_CYC   = 4096;
    localparam int                TMR_W         = 13;
    // Reset pulse sequencer states
    typedef enum logic [0:0] {
        WD_RUN,
        WD_PULSE
    } wd_state_t;
endpackage

// ---- wd_sync.sv ----
module wd_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_ff;

    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_ff <= '0;
            dout    <= '0;
        end else begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end
endmodule // wd_sync

// ---- wd_sys_model.sv ----
module wd_sys_model #(
    parameter logic [7:0] VEC = 8'h5a
) (
    input  wire logic  clk,
    input  wire logic  reset,
    input  wire logic  watchdog_reset,
    input  wire logic  illegal_stop_reset,
    input  wire logic  req,
    output logic [7:0] reset_vector_low,
    output logic       internal_reset,
    output logic       vector_fetch
);
    timeunit 1ns;
    timeprecision 1ps;
    logic irst_ff;
    logic fetch_ff;

    // Every reset request becomes an internal reset, then the core fetches its vector
    always_ff @(posedge clk) begin
        irst_ff  <= !reset && (watchdog_reset || illegal_stop_reset || req);
        fetch_ff <= irst_ff;
    end
    assign internal_reset   = irst_ff;
    assign vector_fetch     = fetch_ff;
    // Vector byte is fixed memory contents
    assign reset_vector_low = VEC;
endmodule // wd_sys_model

// ---- wd_top.sv ----
// Functional notes
// - Watchdog is a 6-bit counter fed by a 12-bit prescaler on the clock.
// - Unserviced overflow after 2^18-2^4 or 2^13-2^4 cycles raises a reset.
// - Any write to the service location clears counter and prescaler stages 12-5.
// - Reading the service location returns reset vector low byte, no side effect.
// - Watchdog reset holds reset pin low 32 cycles and sets cause flag.
// - Stop instruction clears the prescaler.
// - Power-on logic clears the prescaler 4096 cycles after power-up.
// - Any internal reset clears prescaler and counter.
// - A reset vector fetch clears the prescaler.
// - Disable configuration bit set means no watchdog reset can happen.
// - Monitor entry with test voltage on interrupt pin disables while voltage stays.
// - Monitor entry via blank vectors disables until next power-on reset.
// - In break, test voltage on reset pin disables the watchdog.
// - No interrupt requests are issued; reset is the only action.
// - Counting continues in wait mode and resets at timeout if enabled.
// - Stop mode gates the clock to the watchdog and clears its prescaler.
// - Stop instruction while stop is disallowed gives an illegal opcode reset.
// - Rate select one gives the short timeout, zero the long; reset clears it.
// - Disable bit one turns the watchdog off; reset clears it.
module wd_top
    import wd_pkg::*;
#(
    parameter int                 RST_CYC = RST_PULSE_CYC,
    parameter int                 POR_CYC = POR_CLR_CYC
) (
    input  wire logic                   clk,
    input  wire logic                   reset,
    // Wishbone classic slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [WB_ADR_W-1:0]    wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [WB_DAT_W-1:0]    wb_dat_i,
    output logic      [WB_DAT_W-1:0]    wb_dat_o,
    output logic                        wb_ack_o,
    output logic                        wb_err_o,
    // Core and system events, same clock domain
    input  wire logic [7:0]             reset_vector_low,
    input  wire logic                   stop_exec,
    input  wire logic                   stop_mode,
    input  wire logic                   wait_mode,
    input  wire logic                   vector_fetch,
    input  wire logic                   internal_reset,
    input  wire logic                   monitor_entry,
    input  wire logic                   monitor_blank,
    input  wire logic                   break_active,
    // Test voltage detectors on the pins, asynchronous
    input  wire logic                   irq_test_voltage_level,
    input  wire logic                   rst_test_voltage_level,
    // Open-drain reset pin
    input  wire logic                   rst_pin_n_i,
    output logic                        rst_pin_n_o,
    output logic                        rst_pin_n_oe,
    // Reset requests to the system reset logic
    output logic                        watchdog_reset,
    output logic                        illegal_stop_reset
);
    import wd_pkg::*;

    localparam int CHAIN_W = PRE_W + CNT_W;

    logic [1:0]         tv_sync;
    logic               irq_tv;
    logic               rst_tv;
    logic               rst_pin_sync;
    logic [2:0]         cfg_ff;
    logic               cfg_lock_ff;
    logic               cause_wd_ff;
    logic               cause_ill_ff;
    logic               mon_hold_ff;
    logic               mon_blank_ff;
    logic               por_done_ff;
    logic [TMR_W-1:0]   por_cnt_ff;
    logic [TMR_W-1:0]   pulse_cnt_ff;
    wd_state_t          state_ff;
    logic               ack_ff;
    logic               err_ff;
    logic [WB_DAT_W-1:0] rdata_ff;
    logic [CHAIN_W-1:0] chain;
    logic               overflow;
    logic               req;
    logic               wr_req;
    logic               rd_req;
    logic               hit_service;
    logic               hit_cfg;
    logic               hit_status;
    logic               hit_any;
    logic               service_wr;
    logic               disabled;
    logic               wd_fire;
    logic               ill_fire;
    logic               por_clear;
    logic               run;
    logic               clr_all;
    logic               clr_pre;
    logic [WB_DAT_W-1:0] nxt_rdata;
    logic               cause_rd;

    // Pin levels cross into the clock domain before any use
    wd_sync #(
        .W (3)
    ) u_sync (
        .clk   (clk),
        .reset (reset),
        .din   ({rst_pin_n_i, rst_test_voltage_level, irq_test_voltage_level}),
        .dout  ({rst_pin_sync, tv_sync})
    );
    assign irq_tv = tv_sync[0];
    assign rst_tv = tv_sync[1];

    // Bus decode
    assign req         = wb_cyc_i && wb_stb_i && !ack_ff && !err_ff;
    assign wr_req      = req && wb_we_i;
    assign rd_req      = req && !wb_we_i;
    assign hit_service = (wb_adr_i == SERVICE_ADDR);
    assign hit_cfg     = (wb_adr_i == CFG_ADDR);
    assign hit_status  = (wb_adr_i == STATUS_ADDR);
    assign hit_any     = hit_service || hit_cfg || hit_status;

    // Service clear fires on the strobe itself, whatever the data
    assign service_wr  = wr_req && hit_service && wb_sel_i[0];
    assign cause_rd    = rd_req && hit_status;

    // Disable sources combine; any one of them blocks the reset
    assign disabled = cfg_ff[CFG_DIS_BIT]
                   || mon_hold_ff
                   || mon_blank_ff
                   || (break_active && rst_tv);

    // Stop mode gates the clock; wait mode does not
    assign run = !stop_mode && state_ff == WD_RUN;

    // Clears of the counting chain
    assign clr_all = internal_reset || state_ff == WD_PULSE;
    assign clr_pre = stop_exec
                  || stop_mode
                  || vector_fetch
                  || por_clear;

    // Counting chain: 12-bit prescaler then 6-bit counter
    wd_counter #(
        .PW (PRE_W),
        .CW (CNT_W)
    ) u_counter (
        .clk         (clk),
        .reset       (reset),
        .run         (run),
        .clr_all     (clr_all),
        .clr_pre     (clr_pre),
        .clr_service (service_wr),
        .rate_short  (cfg_ff[CFG_RATE_BIT]),
        .chain_ff    (chain),
        .overflow    (overflow)
    );

    // Overflow only resets while enabled; no interrupt path exists
    assign wd_fire  = overflow && !disabled;
    assign ill_fire = stop_exec && !cfg_ff[CFG_STOPEN_BIT]
                   && state_ff == WD_RUN;

    // One-time-writable configuration, cleared by reset
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_ff      <= CFG_RESET;
            cfg_lock_ff <= 1'b0;
        end else if (wr_req && hit_cfg && wb_sel_i[0] && !cfg_lock_ff) begin
            cfg_ff      <= wb_dat_i[2:0];
            cfg_lock_ff <= 1'b1;
        end
    end

    // Monitor entry with test voltage: hold off while either pin keeps it
    always_ff @(posedge clk) begin
        if (reset) begin
            mon_hold_ff <= 1'b0;
        end else if (monitor_entry && irq_tv) begin
            mon_hold_ff <= 1'b1;
        end else if (!irq_tv && !rst_tv) begin
            mon_hold_ff <= 1'b0;
        end
    end

    // Blank-vector monitor entry sticks until the next power-on reset
    always_ff @(posedge clk) begin
        if (reset) begin
            mon_blank_ff <= 1'b0;
        end else if (monitor_entry && monitor_blank && !irq_tv) begin
            mon_blank_ff <= 1'b1;
        end
    end

    // Power-on delay; reset stands for power-on here
    always_ff @(posedge clk) begin
        if (reset) begin
            por_cnt_ff  <= '0;
            por_done_ff <= 1'b0;
        end else if (!por_done_ff) begin
            if (por_cnt_ff == TMR_W'(POR_CYC - 1)) begin
                por_done_ff <= 1'b1;
            end
            por_cnt_ff <= por_cnt_ff + 1'b1;
        end
    end
    assign por_clear = !por_done_ff && por_cnt_ff == TMR_W'(POR_CYC - 1);

    // Reset pulse sequencer: pin held low for a fixed count
    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff     <= WD_RUN;
            pulse_cnt_ff <= '0;
        end else begin
            case (state_ff)
                WD_RUN: begin
                    if (wd_fire || ill_fire) begin
                        state_ff     <= WD_PULSE;
                        pulse_cnt_ff <= '0;
                    end
                end
                WD_PULSE: begin
                    if (pulse_cnt_ff == TMR_W'(RST_CYC - 1)) begin
                        state_ff <= WD_RUN;
                    end
                    pulse_cnt_ff <= pulse_cnt_ff + 1'b1;
                end
                default: begin
                    state_ff <= WD_RUN;
                end
            endcase
        end
    end

    // Open-drain pin: drive low only during the pulse
    assign rst_pin_n_o  = 1'b0;
    assign rst_pin_n_oe = (state_ff == WD_PULSE);

    // One-cycle requests to the system reset logic
    always_ff @(posedge clk) begin
        if (reset) begin
            watchdog_reset     <= 1'b0;
            illegal_stop_reset <= 1'b0;
        end else begin
            watchdog_reset     <= wd_fire && state_ff == WD_RUN;
            illegal_stop_reset <= ill_fire;
        end
    end

    // Cause flags; a new event beats a read-clear in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            cause_wd_ff  <= 1'b0;
            cause_ill_ff <= 1'b0;
        end else begin
            if (wd_fire && state_ff == WD_RUN) begin
                cause_wd_ff <= 1'b1;
            end else if (cause_rd) begin
                cause_wd_ff <= 1'b0;
            end
            if (ill_fire) begin
                cause_ill_ff <= 1'b1;
            end else if (cause_rd) begin
                cause_ill_ff <= 1'b0;
            end
        end
    end

    // Read mux; service location answers with the vector byte only
    always_comb begin
        nxt_rdata = '0;
        if (hit_service) begin
            nxt_rdata[7:0] = reset_vector_low;
        end else if (hit_cfg) begin
            nxt_rdata[2:0]          = cfg_ff;
            nxt_rdata[CFG_LOCK_BIT] = cfg_lock_ff;
        end else if (hit_status) begin
            nxt_rdata[ST_WD_BIT]    = cause_wd_ff;
            nxt_rdata[ST_ILL_BIT]   = cause_ill_ff;
            nxt_rdata[ST_DIS_BIT]   = disabled;
            nxt_rdata[ST_BLANK_BIT] = mon_blank_ff;
            nxt_rdata[ST_HOLD_BIT]  = mon_hold_ff;
            nxt_rdata[ST_CNT_LSB +: CNT_W] = chain[CHAIN_W-1 -: CNT_W];
        end
    end

    // Bus answer one cycle after the request; unmapped gets err
    always_ff @(posedge clk) begin
        if (reset) begin
            ack_ff   <= 1'b0;
            err_ff   <= 1'b0;
            rdata_ff <= '0;
        end else begin
            ack_ff <= req && hit_any;
            err_ff <= req && !hit_any;
            if (rd_req) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end
    assign wb_ack_o = ack_ff;
    assign wb_err_o = err_ff;
    assign wb_dat_o = rdata_ff;
endmodule // wd_top

// ---- wd_top_assertions.sv ----
module wd_top_chk
    import wd_pkg::*;
#(
    parameter int RST_CYC = RST_PULSE_CYC
) (
    input wire logic                clk,
    input wire logic                reset,
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic                wb_we_i,
    input wire logic [WB_ADR_W-1:0] wb_adr_i,
    input wire logic [WB_DAT_W-1:0] wb_dat_o,
    input wire logic                wb_ack_o,
    input wire logic                wb_err_o,
    input wire logic [7:0]          reset_vector_low,
    input wire logic                stop_mode,
    input wire logic                break_active,
    input wire logic                rst_test_voltage_level,
    input wire logic                rst_pin_n_o,
    input wire logic                rst_pin_n_oe,
    input wire logic                watchdog_reset,
    input wire logic                illegal_stop_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] hold_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // Length of the current pin pulse; a counter keeps the check cheap for 32 cycles
    always_ff @(posedge clk) begin
        if (reset || !rst_pin_n_oe) hold_ff <= 8'h00;
        else hold_ff <= hold_ff + 8'h01;
    end

    chk_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
        |=> wb_ack_o || wb_err_o) else $error("bus request not answered next cycle");
    chk_answer_single: assert property ((wb_ack_o || wb_err_o)
        |=> !(wb_ack_o || wb_err_o)) else $error("bus answer longer than one cycle");
    chk_read_vector: assert property (wb_ack_o && !wb_we_i && wb_adr_i == SERVICE_ADDR
        |-> wb_dat_o[7:0] == $past(reset_vector_low)) else $error("service read wrong byte");
    chk_wd_pin: assert property (watchdog_reset
        |-> rst_pin_n_oe && !rst_pin_n_o) else $error("watchdog reset without pin low");
    chk_wd_single: assert property (watchdog_reset
        |=> !watchdog_reset [*8]) else $error("watchdog reset repeated");
    chk_pin_hold: assert property ($fell(rst_pin_n_oe)
        |-> int'(hold_ff) == RST_CYC) else $error("reset pin pulse length wrong");
    chk_illegal_pin: assert property (illegal_stop_reset
        |-> rst_pin_n_oe) else $error("illegal stop reset without pin low");
    chk_stop_freeze: assert property (stop_mode [*3]
        |-> !watchdog_reset) else $error("watchdog reset during stop mode");
    chk_break_off: assert property ((break_active && rst_test_voltage_level) [*5]
        |-> !watchdog_reset) else $error("watchdog reset in break with test voltage");

    cover property (watchdog_reset);
    cover property (illegal_stop_reset);
    cover property (wb_ack_o && wb_we_i && wb_adr_i == SERVICE_ADDR);
endmodule // wd_top_chk

bind wd_top wd_top_chk #(.RST_CYC(RST_CYC)) u_chk (
    .clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
    .wb_err_o, .reset_vector_low, .stop_mode, .break_active, .rst_test_voltage_level,
    .rst_pin_n_o, .rst_pin_n_oe, .watchdog_reset, .illegal_stop_reset
);
